// ===== rtl/windowed_watchdog_counter.sv
// Watchdog with a 7-bit downcounter, reachable over an Avalon-MM slave.
// Assumes halt and wake strobes come from CPU logic on the same clock,
// and that a reset controller stretches the one-cycle reset request.
//
// Register access over Avalon-MM was chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_counter #(
	parameter int unsigned PRESCALE = wdg_pkg::PRESCALE_DEF
) (
	input  wire logic        core_clk_in,
	input  wire logic        nrst_in,
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        halt_exec_in,
	input  wire logic        rtc_irq_enable_in,
	input  wire logic        halt_reset_option_in,
	input  wire logic        hw_watchdog_in,
	input  wire logic        wake_long_in,
	input  wire logic        ext_irq_in,
	input  wire logic        osc_irq_in,
	output logic             wdg_reset_out,
	output logic             counting_out
);

	logic                    rst_s1;
	logic                    rst_n;
	logic                    ack_reg;
	logic                    ack_next;
	logic [31:0]             rdata_reg;
	logic [31:0]             rdata_next;
	logic                    wr_fire;
	logic [7:0]              wd;
	wdg_pkg::wdg_state_t     st_reg;
	wdg_pkg::wdg_state_t     st_next;
	logic [6:0]              cnt_reg;
	logic [6:0]              cnt_next;
	logic                    act_reg;
	logic                    act_next;
	logic [12:0]             dly_reg;
	logic [12:0]             dly_next;
	logic [12:0]             dly_last;
	logic                    fire_reg;
	logic                    fire_next;
	logic                    active;
	logic                    plain_halt;

	wdg_tick_if tick_bus ();

	function automatic logic is_ctrl(input logic [7:0] addr);
		return addr == wdg_pkg::CTRL_ADDR;
	endfunction

	// Reset release through two flops; assertion is still immediate
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	wdg_prescaler #(
		.DIV       (PRESCALE)
	) u_prescaler (
		.clk_in    (core_clk_in),
		.rst_n_in  (rst_n),
		.tick_port (tick_bus)
	);

	// Bus slave: every access waits exactly one cycle
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
	assign avs_readdata_out    = rdata_reg;
	assign wr_fire = avs_write_in & ack_reg & avs_byteenable_in[0] & is_ctrl(avs_address_in);
	assign wd      = avs_writedata_in[7:0];

	always_comb begin
		ack_next   = (avs_read_in | avs_write_in) & ~ack_reg;
		rdata_next = rdata_reg;
		if (avs_read_in & ~ack_reg) begin
			rdata_next = 32'h00000000;
			if (is_ctrl(avs_address_in)) begin
				rdata_next[7:0] = {act_reg, cnt_reg}; // RQ14
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// Option inputs are read live and assumed static while running
	assign active     = act_reg | hw_watchdog_in; // RQ8 RQ17
	assign plain_halt = ~rtc_irq_enable_in & ~halt_reset_option_in;
	assign dly_last   = wake_long_in ? 13'(wdg_pkg::WAKE_LONG - 1)
	                                 : 13'(wdg_pkg::WAKE_SHORT - 1);
	assign tick_bus.run = (st_reg == wdg_pkg::s_run);
	assign counting_out = (st_reg == wdg_pkg::s_run);
	assign wdg_reset_out = fire_reg;

	always_comb begin
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		act_next  = act_reg;
		dly_next  = dly_reg;
		fire_next = 1'b0;
		case (st_reg)
			wdg_pkg::s_run: begin
				if (tick_bus.tick) begin
					cnt_next = cnt_reg - 7'h01; // RQ12 RQ15
					if (active && cnt_reg == wdg_pkg::TRIP_VALUE) begin
						fire_next = 1'b1; // RQ13
					end
				end
				if (halt_exec_in) begin
					if (rtc_irq_enable_in) begin
						st_next  = wdg_pkg::s_active_halt; // RQ5
						cnt_next = cnt_reg;
						// Held counter never reaches 3Fh, so a coinciding trip is dropped
						fire_next = 1'b0;
					end else if (halt_reset_option_in) begin
						fire_next = 1'b1; // RQ4
					end else begin
						// The single step may pass 40h; it never trips here
						st_next   = wdg_pkg::s_halted; // RQ1
						cnt_next  = cnt_reg - 7'h01;
						fire_next = 1'b0;
					end
				end
			end
			wdg_pkg::s_halted: begin
				if (ext_irq_in) begin
					st_next  = wdg_pkg::s_wake; // RQ2
					dly_next = 13'h0000;
				end
			end
			wdg_pkg::s_active_halt: begin
				if (osc_irq_in | ext_irq_in) begin
					st_next = wdg_pkg::s_run; // RQ6
				end
			end
			wdg_pkg::s_wake: begin
				if (dly_reg >= dly_last) begin
					st_next = wdg_pkg::s_run; // RQ2 RQ7
				end else begin
					dly_next = dly_reg + 13'h0001;
				end
			end
			default: begin
				st_next = wdg_pkg::s_run;
			end
		endcase
		// A refresh load wins over a tick's decrement in the same cycle; that tick's trip still fires
		if (wr_fire) begin
			act_next = act_reg | wd[wdg_pkg::ACT_BIT]; // RQ11
			cnt_next = wd[6:0]; // RQ14
			if ((wd[wdg_pkg::ACT_BIT] | active) && !wd[wdg_pkg::TOP_BIT]) begin
				fire_next = 1'b1; // RQ16
			end
		end
	end

	// Every reset restarts through the wake delay with activation cleared
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st_reg   <= wdg_pkg::s_wake; // RQ3 RQ7
			cnt_reg  <= wdg_pkg::CTRL_RESET[6:0]; // RQ10
			act_reg  <= wdg_pkg::CTRL_RESET[7];
			dly_reg  <= 13'h0000;
			fire_reg <= 1'b0;
		end else begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			act_reg  <= act_next;
			dly_reg  <= dly_next;
			fire_reg <= fire_next;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n);

	logic [12:0] wake_len;

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wake_len <= 13'h0000;
		end else if (st_reg == wdg_pkg::s_wake) begin
			wake_len <= wake_len + 13'h0001;
		end else begin
			wake_len <= 13'h0000;
		end
	end

	sequence run_tick_s;
		st_reg == wdg_pkg::s_run && tick_bus.tick && !halt_exec_in && !wr_fire;
	endsequence

	sequence plain_halt_s;
		st_reg == wdg_pkg::s_run && halt_exec_in && plain_halt && !wr_fire;
	endsequence

	sequence halt_wake_s;
		st_reg == wdg_pkg::s_halted && ext_irq_in && !wr_fire;
	endsequence

	trip_reset_a: assert property ( // RQ13
		run_tick_s and (active && cnt_reg == wdg_pkg::TRIP_VALUE) |=> wdg_reset_out)
		else $error("no reset on 40h to 3Fh step");

	free_count_a: assert property ( // RQ15
		run_tick_s |=> cnt_reg == 7'($past(cnt_reg) - 7'h01))
		else $error("counter did not step on tick");

	sw_reset_a: assert property ( // RQ16
		wr_fire && wd[wdg_pkg::ACT_BIT] && !wd[wdg_pkg::TOP_BIT] |=> wdg_reset_out && !cnt_reg[6])
		else $error("software reset missing");

	act_sticky_a: assert property ( // RQ11
		act_reg |=> act_reg)
		else $error("activation bit cleared without reset");

	halt_reset_a: assert property ( // RQ4
		st_reg == wdg_pkg::s_run && halt_exec_in && !rtc_irq_enable_in && halt_reset_option_in
		|=> wdg_reset_out)
		else $error("halt did not reset");

	halt_once_a: assert property ( // RQ1
		plain_halt_s |=> st_reg == wdg_pkg::s_halted && cnt_reg == 7'($past(cnt_reg) - 7'h01)
		##1 !wdg_reset_out)
		else $error("plain halt step wrong");

	halt_quiet_a: assert property ( // RQ1
		st_reg == wdg_pkg::s_halted && !wr_fire |=> $stable(cnt_reg) && !wdg_reset_out)
		else $error("counter moved in halt");

	ahalt_hold_a: assert property ( // RQ5
		st_reg == wdg_pkg::s_active_halt && !wr_fire && !osc_irq_in && !ext_irq_in
		|=> $stable(cnt_reg) && !counting_out)
		else $error("counter moved in active halt");

	resume_now_a: assert property ( // RQ6
		st_reg == wdg_pkg::s_active_halt && (osc_irq_in || ext_irq_in) |=> counting_out)
		else $error("active halt did not resume at once");

	wake_hold_a: assert property ( // RQ2
		halt_wake_s |=> !counting_out [*8])
		else $error("counting resumed too early");

	wake_bound_a: assert property ( // RQ2 RQ7
		st_reg == wdg_pkg::s_wake |-> wake_len <= 13'(wdg_pkg::WAKE_LONG))
		else $error("wake delay too long");

	wake_exact_a: assert property ( // RQ7
		$past(st_reg) == wdg_pkg::s_wake && st_reg == wdg_pkg::s_run
		|-> wake_len == ($past(wake_long_in) ? 13'(wdg_pkg::WAKE_LONG)
		                                     : 13'(wdg_pkg::WAKE_SHORT)))
		else $error("wake delay length wrong");

	reset_state_a: assert property ( // RQ3 RQ10
		$rose(rst_n) |-> !act_reg && cnt_reg == wdg_pkg::CTRL_RESET[6:0] && !counting_out)
		else $error("bad state after reset");

	bus_wait_a: assert property ( // RQ14
		(avs_read_in || avs_write_in) && !ack_reg |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("bus wait state not exactly one cycle");

	write_load_a: assert property ( // RQ14
		wr_fire |=> cnt_reg == $past(wd[6:0]))
		else $error("write did not load counter");

	read_back_a: assert property ( // RQ14
		avs_read_in && !ack_reg && is_ctrl(avs_address_in) |=> avs_readdata_out[7:0] == $past({act_reg, cnt_reg}))
		else $error("read data not the control register");

	act_set_a: assert property ( // RQ11
		wr_fire && wd[wdg_pkg::ACT_BIT] |=> act_reg)
		else $error("activation bit not set by write");

	off_quiet_a: assert property ( // RQ11 RQ15
		!active && !wr_fire && !halt_exec_in |=> !wdg_reset_out)
		else $error("reset while watchdog disabled");

	no_spurious_a: assert property ( // RQ13
		st_reg == wdg_pkg::s_run && !halt_exec_in && !wr_fire
		&& !(tick_bus.tick && cnt_reg == wdg_pkg::TRIP_VALUE) |=> !wdg_reset_out)
		else $error("reset without a trip");

	ahalt_enter_a: assert property ( // RQ5
		st_reg == wdg_pkg::s_run && halt_exec_in && rtc_irq_enable_in && !wr_fire
		|=> st_reg == wdg_pkg::s_active_halt && !wdg_reset_out && cnt_reg == $past(cnt_reg))
		else $error("active halt entry wrong");

	halt_stay_a: assert property ( // RQ2
		st_reg == wdg_pkg::s_halted && !ext_irq_in |=> st_reg == wdg_pkg::s_halted)
		else $error("halt left without external interrupt");
endmodule // windowed_watchdog_counter

`default_nettype wire

// ===== rtl/wdg_pkg.sv
// Constants, field layout and state type of the windowed watchdog counter.
// Assumes one 200 MHz core clock that also serves as the oscillator and CPU clock.
//
// Overview of operation
// RQ1 - A halt with the RTC interrupt enable and halt-reset option both 0 steps the counter once, then freezes it with no reset.
// RQ2 - An external interrupt that ends such a halt restarts counting after 256 or 4096 clocks.
// RQ3 - A reset that ends such a halt leaves the watchdog disabled in its reset state unless the hardware option is set.
// RQ4 - A halt with the RTC interrupt enable at 0 and the halt-reset option at 1 produces a reset.
// RQ5 - A halt with the RTC interrupt enable at 1 enters active halt with no reset and the counter held.
// RQ6 - An oscillator or external interrupt ending active halt restarts counting at once.
// RQ7 - A reset ending active halt restarts counting only after 256 or 4096 clocks.
// RQ8 - With the hardware option set the watchdog is always active and the activation bit is ignored.
// RQ9 - Software should reload the counter just before halting while the watchdog is enabled.
// RQ10 - The control register resets to 7Fh.
// RQ11 - The activation bit is set by software, cleared only by reset, and lets the watchdog reset the device.
// RQ12 - The counter steps down once every 16384 oscillator cycles from a free-running prescaler.
// RQ13 - An active watchdog whose counter steps from 40h to 3Fh starts a reset.
// RQ14 - Bits 6:0 read the counter and a write loads them.
// RQ15 - The counter keeps counting down while the watchdog is not activated.
// RQ16 - A write that leaves the watchdog active with bit 6 clear resets the device at once.
// RQ17 - The hardware and halt-reset options are static configuration inputs.

`default_nettype none

package wdg_pkg;
	localparam int unsigned CTRL_INDEX   = 32'h0000002A;
	localparam logic [7:0]  CTRL_ADDR    = 8'(CTRL_INDEX * 4);
	localparam int unsigned ACT_BIT      = 7;
	localparam int unsigned TOP_BIT      = 6;
	localparam int unsigned CNT_W        = 7;
	localparam logic [7:0]  CTRL_RESET   = 8'h7F;
	localparam logic [6:0]  TRIP_VALUE   = 7'h40;
	localparam int unsigned PRESCALE_DEF = 16384;
	localparam int unsigned WAKE_SHORT   = 256;
	localparam int unsigned WAKE_LONG    = 4096;
	localparam int unsigned WAKE_W       = 13;

	typedef enum logic [2:0] {
		s_run,
		s_halted,
		s_active_halt,
		s_wake
	} wdg_state_t;
endpackage

`default_nettype wire

// ===== rtl/wdg_tick_if.sv
// Tick carrier between the watchdog core and its prescaler.
// Assumes both ends run on the same core clock.

`timescale 1ns/1ps
`default_nettype none

interface wdg_tick_if;
	logic run;
	logic tick;
	modport gen  (input run, output tick);
	modport user (output run, input tick);
endinterface

`default_nettype wire

// ===== rtl/wdg_prescaler.sv
// Free-running prescaler that emits one tick every DIV cycles while allowed to run.
// Assumes DIV of at least 16 and a reset already synchronised to clk_in.

`timescale 1ns/1ps
`default_nettype none

module wdg_prescaler #(
	parameter int unsigned DIV = wdg_pkg::PRESCALE_DEF
) (
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	wdg_tick_if.gen    tick_port
);
	localparam int unsigned W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] div_reg;
	logic [W-1:0] div_next;
	logic         tick_reg;
	logic         tick_next;

	// Frozen rather than cleared when stopped, so a resume keeps the old phase
	always_comb begin
		div_next  = div_reg;
		tick_next = 1'b0;
		if (tick_port.run) begin
			if (div_reg == LAST) begin // RQ12
				div_next  = '0;
				tick_next = 1'b1;
			end else begin
				div_next = div_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_port.tick = tick_reg;

	tick_spacing_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ12
		tick_reg |=> !tick_reg [*8])
		else $error("prescaler ticks too close together");
endmodule // wdg_prescaler

`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the windowed watchdog counter, random register values mixed with corner cases.
// Assumes PRESCALE set to 16 here and the control register at the package byte address.

`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam logic [7:0] A = wdg_pkg::CTRL_ADDR;
	logic        clk  = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  adr  = 8'h00;
	logic        rd   = 1'b0;
	logic        wr   = 1'b0;
	logic [31:0] wdat = 32'h00000000;
	logic [3:0]  be   = 4'h0;
	logic        halt = 1'b0;
	logic        rtc  = 1'b0;
	logic        opt  = 1'b0;
	logic        hw   = 1'b0;
	logic        wl   = 1'b0;
	logic        ext  = 1'b0;
	logic        osc  = 1'b0;
	logic [31:0] rdat;
	logic        wait_o;
	logic        rst_o;
	logic        cnt_o;
	logic [31:0] seed = 32'h00010DA0;
	logic [31:0] v;
	logic [7:0]  r;
	logic [7:0]  c;
	logic        hit;
	int          errors = 0;
	int          compares = 0;
	int          n;

	always #2.5 clk = ~clk;

	windowed_watchdog_counter #(.PRESCALE(16)) dut_u (.core_clk_in(clk), .nrst_in(nrst), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wait_o), .halt_exec_in(halt), .rtc_irq_enable_in(rtc),
		.halt_reset_option_in(opt), .hw_watchdog_in(hw), .wake_long_in(wl), .ext_irq_in(ext), .osc_irq_in(osc),
		.wdg_reset_out(rst_o), .counting_out(cnt_o));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// A tick may land between write and read, so counter values get a small window
	function automatic logic in_rng(input logic [7:0] x, input logic [7:0] lo, input logic [7:0] hi);
		return (x >= lo) && (x <= hi);
	endfunction

	task automatic report_and_stop();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One Avalon transfer; read data lands in v at the edge that ends the wait
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] b);
		int i;
		@(posedge clk);
		adr <= a;
		rd <= !w;
		wr <= w;
		wdat <= {24'h000000, d};
		be <= b;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (wait_o === 1'b0)
				break;
		end
		if (i == 20) begin
			errors++;
			report_and_stop();
		end
		v = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic see_rst(input int lim, output logic h);
		h = 1'b0;
		for (int i = 0; i < lim; i++) begin
			@(posedge clk);
			if (rst_o === 1'b1) begin
				h = 1'b1;
				break;
			end
		end
	endtask

	task automatic wait_cnt(output int k);
		for (k = 0; k < 5000; k++) begin
			@(posedge clk);
			if (cnt_o === 1'b1)
				break;
		end
		if (k == 5000) begin
			errors++;
			report_and_stop();
		end
	endtask

	// Options are set while reset is held; only wl is changed again later, during the plain halt test
	task automatic do_reset(input logic l, input logic o, input logic h, input int lo);
		@(posedge clk);
		nrst <= 1'b0;
		wl <= l;
		opt <= o;
		hw <= h;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		wait_cnt(n);
		check(n >= lo && n <= lo + 8, 1);
	endtask

	task automatic strobe(input logic [2:0] m);
		@(posedge clk);
		{halt, ext, osc} <= m;
		@(posedge clk);
		{halt, ext, osc} <= 3'b000;
	endtask

	initial begin
		do_reset(1'b0, 1'b0, 1'b0, 256);
		bus(1'b0, A, 8'h00, 4'hF);
		check(in_rng(v[7:0], 8'h7E, 8'h7F), 1);
		bus(1'b0, 8'h00, 8'h00, 4'hF);
		check(v, 32'h00000000);
		repeat (4) begin
			seed = xs(seed);
			r = {2'b01, seed[5:0]};
			bus(1'b1, A, r, 4'h1);
			bus(1'b0, A, 8'h00, 4'hF);
			check(in_rng(v[7:0], r - 8'h01, r), 1);
		end
		bus(1'b1, A, 8'h7F, 4'h1);
		bus(1'b1, A, 8'h00, 4'h0);
		bus(1'b1, 8'h00, 8'h00, 4'h1);
		repeat (160) @(posedge clk);
		bus(1'b0, A, 8'h00, 4'hF);
		check(in_rng(v[7:0], 8'h73, 8'h76), 1);
		see_rst(1000, hit);
		check(hit, 1'b0);
		$display("test done: register and free run");
		do_reset(1'b0, 1'b0, 1'b0, 256);
		for (int j = 0; j < 2; j++) begin
			rtc <= 1'b1;
			bus(1'b1, A, 8'hFF, 4'h1);
			strobe(3'b100);
			rtc <= 1'b0;
			bus(1'b0, A, 8'h00, 4'hF);
			c = v[7:0];
			repeat (100) @(posedge clk);
			bus(1'b0, A, 8'h00, 4'hF);
			check(v[7:0], c);
			strobe(j ? 3'b010 : 3'b001);
			@(posedge clk);
			check(cnt_o, 1'b1);
		end
		bus(1'b1, A, 8'hC1, 4'h1);
		see_rst(60, hit);
		check(hit, 1'b1);
		$display("test done: active halt and trip");
		do_reset(1'b1, 1'b0, 1'b0, 4096);
		bus(1'b1, A, 8'hC1, 4'h1);
		strobe(3'b100);
		bus(1'b0, A, 8'h00, 4'hF);
		check(in_rng(v[7:0], 8'hBF, 8'hC0), 1);
		see_rst(300, hit);
		check(hit, 1'b0);
		wl <= 1'b0;
		strobe(3'b010);
		wait_cnt(n);
		check(n >= 255 && n <= 260, 1);
		see_rst(60, hit);
		check(hit, 1'b1);
		$display("test done: plain halt");
		do_reset(1'b0, 1'b0, 1'b0, 256);
		strobe(3'b100);
		do_reset(1'b0, 1'b0, 1'b0, 256);
		bus(1'b1, A, 8'h41, 4'h1);
		see_rst(60, hit);
		check(hit, 1'b0);
		bus(1'b1, A, 8'hFF, 4'h1);
		bus(1'b1, A, 8'h7F, 4'h1);
		bus(1'b0, A, 8'h00, 4'hF);
		check(v[7], 1'b1);
		bus(1'b1, A, 8'hBF, 4'h1);
		see_rst(4, hit);
		check(hit, 1'b1);
		$display("test done: activation and software reset");
		do_reset(1'b0, 1'b1, 1'b0, 256);
		strobe(3'b100);
		see_rst(4, hit);
		check(hit, 1'b1);
		do_reset(1'b0, 1'b0, 1'b1, 256);
		bus(1'b1, A, 8'h41, 4'h1);
		see_rst(60, hit);
		check(hit, 1'b1);
		$display("test done: options");
		report_and_stop();
	end
endmodule // tb_top

`default_nettype wire
